// ### logic/sti_pkg.sv
// sti_pkg: constants and types for the target-side information transfer port
// assumes: 200 MHz system clock; bus lines handled as active-high levels
package sti_pkg;
    typedef enum logic [2:0] {
        STI_PH_DATA_OUT = 3'h0,
        STI_PH_DATA_IN = 3'h1,
        STI_PH_COMMAND = 3'h2,
        STI_PH_STATUS = 3'h3,
        STI_PH_MSG_OUT = 3'h6,
        STI_PH_MSG_IN = 3'h7
    } sti_phase_t;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int BUS_SETTLE_NS = 400;
    localparam int BUS_SETTLE_CYC = (BUS_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int BUS_CLEAR_NS = 800;
    localparam int BUS_CLEAR_CYC = (BUS_CLEAR_NS * 1000) / CLK_PERIOD_PS;
    localparam int RESET_HOLD_US = 25;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_US * 1000000) / CLK_PERIOD_PS;
    localparam int SYNC_STAGES = 2;
    localparam logic [6:0] SETTLE_LOAD = 7'(BUS_SETTLE_CYC);
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] PHASE_RESET = 3'h0;
endpackage : sti_pkg

// ### logic/sti_sync.sv
// sti_sync: multi-stage synchroniser for a vector of asynchronous levels
// assumes: inputs come from board pins (bus lines or straps), outside the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module sti_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule : sti_sync
`default_nettype wire

// ### logic/sti_target.sv
// sti_target: target-side phase encoding and byte handshake on the bus
// assumes: bus pins active high here; open-collector drivers outside obey oe
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE_01] drive the six legal phase codes on msg, c/d, i/o; never reserved ones
// [RULE_02] initiator ignores phase lines until it sees req asserted
// [RULE_03] each byte moves with one req/ack four-step interlock
// [RULE_04] inbound data valid before req and held until ack rises
// [RULE_05] target always drives correct parity on inbound bytes
// [RULE_06] parity is odd over nine lines
// [RULE_07] initiator holds outbound data from ack until req falls
// [RULE_08] check outbound parity only when checking is enabled
// [RULE_09] bsy held, sel low; phase lines settle before first req, held after
// [RULE_10] bus settle delay is at least 400 ns
// [RULE_11] command phase collects command bytes with c/d only asserted
// [RULE_12] data in sends device data; data out receives write data
// [RULE_13] message out entered only on attention, when the target is ready
// [RULE_14] message out continues while atn asserted, ends when atn false
// [RULE_15] bsy, sel, req, ack hold between phases
// [RULE_16] initiator drops atn only at reset, bus free, or last msg byte
// [RULE_17] initiator keeps answering handshakes while atn is asserted
// [RULE_18] release all lines except rst within 800 ns of rst
// [RULE_19] rst held at least 25 us; other lines untrusted meanwhile
// [RULE_20] the target never asserts rst
// [RULE_21] after reset the bus returns to bus free
// [RULE_22] hard reset mode clears commands, reservations and modes
// [RULE_23] soft reset mode keeps identified commands, reservations, modes
// [RULE_24] bus free, arbitration, selection, transfer; any phase may go free
// [RULE_25] ack, atn, rst, sel, bsy pass synchronisers before use
module sti_target (
    input wire logic clk_sys,
    input wire logic rst,
    // bus side
    input wire logic ack_in,
    input wire logic atn_in,
    input wire logic rst_in,
    input wire logic sel_in,
    input wire logic bsy_in,
    input wire logic [7:0] db_in,
    input wire logic dbp_in,
    output logic [7:0] db_out,
    output logic dbp_out,
    output logic db_oe,
    output logic req_out,
    output logic msg_out,
    output logic cd_out,
    output logic io_out,
    output logic bsy_out,
    output logic sel_out,
    output logic rst_bus_out,
    // option_jumper_header straps
    input wire logic option_jumper_header_hard,
    input wire logic parity_check_en,
    // user side
    input wire logic connected,
    input wire logic phase_start,
    input wire sti_pkg::sti_phase_t phase_sel,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic last_byte,
    input wire logic phase_end,
    input wire logic go_free,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_parity_err,
    output logic in_phase,
    output logic atn_pending,
    output logic phase_done,
    output logic bus_reset_active,
    output logic hard_reset_pulse,
    output logic soft_resume_pulse
);
    typedef enum logic [2:0] {
        STI_IDLE,
        STI_SETTLE,
        STI_WAIT_DATA,
        STI_REQ_HI,
        STI_WAIT_ACK_LO,
        STI_HOLD
    } sti_state_t;

    function automatic logic odd_par(input logic [7:0] b);
        odd_par = ~(^b);
    endfunction : odd_par

    sti_state_t state;
    sti_state_t next_state;
    logic ack_s;
    logic atn_s;
    logic rst_s;
    logic sel_s;
    logic bsy_s;
    logic rst_s_d;
    logic [6:0] settle_cnt;
    logic [2:0] phase;
    logic inbound;
    logic is_msg_out;
    logic phase_ok;
    logic start_ok;
    logic rst_rise;
    logic rst_fall;
    logic ack_seen_hi;
    logic ack_seen_lo;
    logic outbound_done;
    logic par_bad;
    logic mo_last;
    logic [7:0] db_s;
    logic dbp_s;
    logic hard_s;
    logic pce_s;

    // [RULE_25]
    sti_sync #(.WIDTH(14)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({ack_in, atn_in, rst_in, sel_in, bsy_in, dbp_in, db_in}),
        .q({ack_s, atn_s, rst_s, sel_s, bsy_s, dbp_s, db_s})
    );

    // straps are board pins too: synchronise before any logic reads them
    sti_sync #(.WIDTH(2)) u_strap_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({option_jumper_header_hard, parity_check_en}),
        .q({hard_s, pce_s})
    );

    assign inbound = phase[0];
    assign is_msg_out = (phase == 3'(sti_pkg::STI_PH_MSG_OUT));
    // reserved codes 4 and 5 are refused at phase start [RULE_01]
    assign phase_ok = (phase_sel != 3'h4) && (phase_sel != 3'h5);
    // message out only while attention is pending [RULE_13]
    assign start_ok = phase_start && phase_ok && connected && !rst_s
        && ((phase_sel != sti_pkg::STI_PH_MSG_OUT) || atn_s);
    assign rst_rise = rst_s && !rst_s_d;
    assign rst_fall = !rst_s && rst_s_d;
    assign ack_seen_hi = ack_s;
    assign ack_seen_lo = !ack_s;
    // odd parity over nine lines [RULE_06] [RULE_08]
    assign par_bad = pce_s && (dbp_s != odd_par(db_s));
    // last message byte when atn has fallen by the time ack rises [RULE_14]
    assign mo_last = is_msg_out && !atn_s;
    assign outbound_done = (state == STI_REQ_HI) && ack_seen_hi && !inbound;

    // phase and handshake sequencing [RULE_03] [RULE_24]
    always_comb begin
        next_state = state;
        unique case (state)
            STI_IDLE: begin
                if (start_ok) begin
                    next_state = STI_SETTLE;
                end
            end
            STI_SETTLE: begin
                // phase lines stand a settle delay before first req [RULE_09] [RULE_10]
                if (settle_cnt == 7'h00) begin
                    next_state = STI_WAIT_DATA;
                end
            end
            STI_WAIT_DATA: begin
                if (is_msg_out && !atn_s) begin
                    next_state = STI_HOLD;
                end else if (phase_end && !is_msg_out) begin
                    next_state = STI_HOLD;
                end else if (!inbound || tx_valid) begin
                    next_state = STI_REQ_HI;
                end
            end
            STI_REQ_HI: begin
                if (ack_seen_hi) begin
                    next_state = STI_WAIT_ACK_LO;
                end
            end
            STI_WAIT_ACK_LO: begin
                // phase lines held until ack falls [RULE_09]
                if (ack_seen_lo) begin
                    next_state = STI_WAIT_DATA;
                end
            end
            STI_HOLD: begin
                next_state = STI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= STI_IDLE;
        end else if (rst_s) begin
            // bus reset overrides every phase, back to bus free [RULE_18] [RULE_21]
            state <= STI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            settle_cnt <= 7'h00;
            phase <= sti_pkg::PHASE_RESET;
        end else if (state == STI_IDLE && start_ok) begin
            settle_cnt <= sti_pkg::SETTLE_LOAD;
            phase <= phase_sel;
        end else if (state == STI_SETTLE && settle_cnt != 7'h00) begin
            settle_cnt <= settle_cnt - 7'h01;
        end
    end

    // bus drivers: lines released while bus reset is seen [RULE_18]
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_out <= 1'b0;
            msg_out <= 1'b0;
            cd_out <= 1'b0;
            io_out <= 1'b0;
            bsy_out <= 1'b0;
            sel_out <= 1'b0;
            db_oe <= 1'b0;
            db_out <= sti_pkg::BYTE_RESET;
            dbp_out <= 1'b0;
            rst_bus_out <= 1'b0;
        end else begin
            rst_bus_out <= 1'b0; // [RULE_20]
            sel_out <= 1'b0; // [RULE_09]
            if (rst_s) begin
                req_out <= 1'b0;
                msg_out <= 1'b0;
                cd_out <= 1'b0;
                io_out <= 1'b0;
                bsy_out <= 1'b0;
                db_oe <= 1'b0;
            end else begin
                // bsy held through connection; drops on go_free in idle or on bus reset [RULE_09] [RULE_15]
                if (go_free && state == STI_IDLE) begin
                    bsy_out <= 1'b0;
                end else if (connected) begin
                    bsy_out <= 1'b1;
                end
                if (state == STI_IDLE && start_ok) begin
                    // phase code onto msg, c/d, i/o [RULE_01] [RULE_11] [RULE_12]
                    {msg_out, cd_out, io_out} <= phase_sel;
                end
                if (state == STI_WAIT_DATA && next_state == STI_REQ_HI) begin
                    if (inbound) begin
                        // data and parity set up a cycle ahead of req [RULE_04] [RULE_05]
                        db_out <= tx_byte;
                        dbp_out <= odd_par(tx_byte);
                        db_oe <= 1'b1;
                    end
                end else if (state == STI_REQ_HI && next_state == STI_REQ_HI
                        && inbound) begin
                    req_out <= 1'b1; // [RULE_03]
                end else if (state == STI_REQ_HI && ack_seen_hi) begin
                    req_out <= 1'b0;
                end else if (state == STI_WAIT_ACK_LO && ack_seen_lo) begin
                    db_oe <= 1'b0;
                end
                if (state == STI_WAIT_DATA && next_state == STI_REQ_HI
                        && !inbound) begin
                    req_out <= 1'b1;
                end
            end
        end
    end

    // user-side status and received bytes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_valid <= 1'b0;
            rx_byte <= sti_pkg::BYTE_RESET;
            rx_parity_err <= 1'b0;
            tx_ready <= 1'b0;
            in_phase <= 1'b0;
            atn_pending <= 1'b0;
            phase_done <= 1'b0;
            bus_reset_active <= 1'b0;
            hard_reset_pulse <= 1'b0;
            soft_resume_pulse <= 1'b0;
            rst_s_d <= 1'b0;
        end else begin
            rst_s_d <= rst_s;
            // byte taken while initiator holds it, before req falls [RULE_07]
            rx_valid <= outbound_done;
            if (outbound_done) begin
                rx_byte <= db_s;
                rx_parity_err <= par_bad; // [RULE_08]
            end
            tx_ready <= (state == STI_WAIT_DATA) && inbound
                && (next_state == STI_REQ_HI);
            // drops in the same cycle as bsy when a bus reset is seen
            in_phase <= (state != STI_IDLE) && !rst_s;
            atn_pending <= atn_s && bsy_s;
            phase_done <= (state == STI_HOLD) || (mo_last && outbound_done);
            bus_reset_active <= rst_s;
            // hard mode: drop commands, reservations, modes [RULE_22]
            hard_reset_pulse <= rst_rise && hard_s;
            // soft mode: resume identified commands after reset ends [RULE_23]
            soft_resume_pulse <= rst_fall && !hard_s;
        end
    end
endmodule : sti_target
`default_nettype wire

// ### test/sti_target_chk.sv
// sti_target_chk: timing relations on the target port pins
// assumes: bound to sti_target; one clock domain, async high reset
`timescale 1ns/1ps
`default_nettype none
module sti_target_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ack_in,
    input wire logic rst_in,
    input wire logic [7:0] db_out,
    input wire logic dbp_out,
    input wire logic db_oe,
    input wire logic req_out,
    input wire logic msg_out,
    input wire logic cd_out,
    input wire logic io_out,
    input wire logic bsy_out,
    input wire logic sel_out,
    input wire logic rst_bus_out,
    input wire logic parity_check_en,
    input wire logic rx_valid,
    input wire logic rx_parity_err,
    input wire logic in_phase,
    input wire logic atn_pending
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic [2:0] ph = {msg_out, cd_out, io_out};
    logic [2:0] ph_q;
    logic [7:0] age;
    // cycles since the phase lines last moved, saturating
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph_q <= 3'h0;
            age <= 8'h00;
        end else begin
            ph_q <= ph;
            age <= (ph_q != ph) ? 8'h00 : age + {7'h00, age != 8'hFF};
        end
    end
    a_code_legal: assert property (in_phase |-> ph != 3'h4 && ph != 3'h5)
        else $error("reserved phase code driven");
    a_settle_req: assert property ($rose(req_out) |-> age >= 8'h4F)
        else $error("req raised before phase lines settled");
    a_req_waits: assert property (req_out && !ack_in && !rst_in && !$past(rst_in)
        && !$past(rst_in, 2) && !$past(rst_in, 3) |=> req_out)
        else $error("req dropped without ack");
    a_req_drops: assert property (req_out && ack_in |-> ##[1:5] !req_out)
        else $error("req not dropped after ack");
    a_data_held: assert property (req_out && io_out |-> db_oe && $stable(db_out)
        && $stable(dbp_out))
        else $error("inbound data moved during req");
    a_odd_parity: assert property (db_oe |-> ^{db_out, dbp_out})
        else $error("inbound parity not odd");
    a_bsy_held: assert property (in_phase |-> bsy_out && !sel_out)
        else $error("bsy or sel wrong in phase");
    a_never_rst: assert property (!rst_bus_out)
        else $error("target drove rst");
    a_parity_off: assert property (rx_valid && !parity_check_en |-> !rx_parity_err)
        else $error("parity flagged while checking off");
    a_msg_atn: assert property ($rose(ph == 3'h6) |-> $past(atn_pending)
        || $past(atn_pending, 2))
        else $error("message out without attention");
    a_rst_clear: assert property ($rose(rst_in) |-> ##[1:160]
        !(req_out || db_oe || bsy_out || ph != 3'h0))
        else $error("bus not released on reset");
endmodule : sti_target_chk
bind sti_target sti_target_chk sti_target_chk_i (.*);
`default_nettype wire

// ### test/sti_init_model.sv
// sti_init_model: behavioural initiator answering the target handshake
// assumes: active-high levels; stall holds off ack, atn_go starts a message
`timescale 1ns/1ps
`default_nettype none
module sti_init_model (
    input wire logic clk_sys,
    input wire logic req_out,
    input wire logic io_out,
    input wire logic msg_out,
    input wire logic [7:0] db_out,
    input wire logic dbp_out,
    input wire logic [7:0] out_byte,
    input wire logic bad_par,
    input wire logic stall,
    input wire logic atn_go,
    output logic ack_in,
    output logic atn_in,
    output logic [7:0] db_in,
    output logic dbp_in,
    output logic seen,
    output logic [8:0] rx_seen
);
    int left = 0;
    initial begin
        {ack_in, atn_in, db_in, dbp_in, seen, rx_seen} = 21'h000000;
    end
    // two-byte message; atn drops between req and ack of the last byte
    always @(posedge atn_go) begin
        left = 2;
        atn_in = 1'b1;
    end
    always @(posedge req_out) begin
        @(posedge clk_sys);
        while (stall) @(posedge clk_sys);
        #1;
        if (req_out) begin
            if (!io_out) begin
                db_in = out_byte;
                dbp_in = ~^out_byte ^ bad_par;
            end
            if (msg_out && !io_out) left = left - 1;
            if (msg_out && !io_out && left == 0) atn_in = 1'b0;
            @(posedge clk_sys);
            #1;
            rx_seen = {dbp_out, db_out};
            seen = io_out;
            ack_in = 1'b1;
            @(posedge clk_sys);
            #1;
            seen = 1'b0;
            wait (!req_out);
            @(posedge clk_sys);
            #1;
            ack_in = 1'b0;
            {db_in, dbp_in} = ~{db_in, dbp_in};
        end
    end
endmodule : sti_init_model
`default_nettype wire

// ### test/sti_target_tb_top.sv
// sti_target_tb_top: self-checking bench for the target port
// assumes: sti_init_model answers the bus; bench plays the user side
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin logic [31:0] ev, sv; ev = 32'(e); sv = 32'(s); \
tests_run++; if (sv !== ev) begin fails++; \
$display("MISMATCH %s exp %0h got %0h", n, ev, sv); end end
`define WAITF(c) begin int k; k = 0; while (!(c) && k < 2000) begin \
@(posedge clk_sys); k++; end if (k >= 2000) begin fails++; \
$display("MISMATCH wait exp 1 got 0"); end_of_test(); end end
module sti_target_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ack_in, atn_in, dbp_in, dbp_out, db_oe, req_out, msg_out, cd_out;
    logic io_out, bsy_out, sel_out, rst_bus_out, tx_ready, rx_valid;
    logic rx_parity_err, in_phase, atn_pending, phase_done, bus_reset_active;
    logic hard_reset_pulse, soft_resume_pulse, seen, bad_par, stall, atn_go;
    logic rst_in, option_jumper_header_hard, parity_check_en, connected;
    logic phase_start, tx_valid, phase_end, go_free;
    logic [7:0] db_in, db_out, rx_byte, tx_byte, out_byte;
    logic [8:0] rx_seen;
    logic [8:0] exp_in[$], exp_rx[$];
    sti_pkg::sti_phase_t phase_sel;
    int fails = 0, tests_run = 0, cyc = 0, hits;
    sti_target sti_target_i (.clk_sys, .rst, .ack_in, .atn_in, .rst_in,
        .sel_in(1'b0), .bsy_in(bsy_out), .db_in, .dbp_in, .db_out, .dbp_out,
        .db_oe, .req_out, .msg_out, .cd_out, .io_out, .bsy_out, .sel_out,
        .rst_bus_out, .option_jumper_header_hard, .parity_check_en, .connected,
        .phase_start, .phase_sel, .tx_valid, .tx_byte, .last_byte(1'b0),
        .phase_end, .go_free, .tx_ready, .rx_valid, .rx_byte, .rx_parity_err,
        .in_phase, .atn_pending, .phase_done, .bus_reset_active,
        .hard_reset_pulse, .soft_resume_pulse);
    sti_init_model sti_init_model_i (.clk_sys, .req_out, .io_out, .msg_out,
        .db_out, .dbp_out, .out_byte, .bad_par, .stall, .atn_go, .ack_in,
        .atn_in, .db_in, .dbp_in, .seen, .rx_seen);
    always #2.5 clk_sys = ~clk_sys;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end
    // oldest note against each byte that shows up
    always @(posedge clk_sys) begin
        if (seen === 1'b1) `CHK("in_byte", exp_in.pop_front(), rx_seen)
        if (rx_valid === 1'b1) `CHK("rx", exp_rx.pop_front(), {rx_parity_err, rx_byte})
    end
    task automatic start(input sti_pkg::sti_phase_t p);
        repeat (2) @(negedge clk_sys);
        phase_sel = p;
        phase_start = 1'b1;
        @(negedge clk_sys);
        phase_start = 1'b0;
    endtask : start
    task automatic run_phase(input sti_pkg::sti_phase_t p, input int n,
        input logic bad);
        logic [7:0] b;
        start(p);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (p[0]) begin
                exp_in.push_back({~^b, b});
                tx_byte = b;
                tx_valid = 1'b1;
                `WAITF(tx_ready)
                @(negedge clk_sys);
            end else begin
                out_byte = b;
                bad_par = bad && i == 0;
                exp_rx.push_back({bad_par & parity_check_en, b});
                `WAITF(rx_valid)
                @(negedge clk_sys);
            end
        end
        tx_valid = 1'b0;
        // outbound bytes keep being requested until the phase is ended
        phase_end = (p != sti_pkg::STI_PH_MSG_OUT);
        `WAITF(phase_done)
        @(negedge clk_sys);
        phase_end = 1'b0;
        `CHK("released", 2'h0, {req_out, db_oe})
        `CHK("phase", p, {msg_out, cd_out, io_out})
        `CHK("in_phase", 1'b0, in_phase)
        $display("test phase %0h done", p);
    endtask : run_phase
    initial begin
        {rst_in, connected, phase_start, tx_valid, phase_end, go_free} = 6'h00;
        {bad_par, stall, atn_go, tx_byte, out_byte} = 19'h00000;
        {option_jumper_header_hard, parity_check_en} = 2'h3;
        phase_sel = sti_pkg::STI_PH_DATA_OUT;
        void'($urandom(32'h56AA));
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        connected = 1'b1;
        for (int i = 0; i < 4; i++) run_phase(sti_pkg::sti_phase_t'(i), 3, 1'b0);
        run_phase(sti_pkg::STI_PH_MSG_IN, 3, 1'b0);
        run_phase(sti_pkg::STI_PH_COMMAND, 2, 1'b1);
        parity_check_en = 1'b0;
        run_phase(sti_pkg::STI_PH_DATA_OUT, 2, 1'b1);
        for (int r = 0; r < 2; r++) begin
            start(r ? sti_pkg::sti_phase_t'(3'h4) : sti_pkg::STI_PH_MSG_OUT);
            repeat (100) @(negedge clk_sys);
            `CHK("refused", 2'h0, {in_phase, req_out})
        end
        atn_go = 1'b1;
        repeat (4) @(negedge clk_sys);
        atn_go = 1'b0;
        `CHK("atn_pending", 1'b1, atn_pending)
        run_phase(sti_pkg::STI_PH_MSG_OUT, 2, 1'b0);
        for (int h = 1; h >= 0; h--) begin
            option_jumper_header_hard = h[0];
            stall = 1'b1;
            start(sti_pkg::STI_PH_DATA_IN);
            tx_valid = 1'b1;
            `WAITF(req_out)
            @(negedge clk_sys);
            rst_in = 1'b1;
            tx_valid = 1'b0;
            hits = 0;
            repeat (20) @(posedge clk_sys) hits += hard_reset_pulse;
            `CHK("hard", h, hits)
            `CHK("cleared", 3'h4, {bus_reset_active, in_phase, req_out})
            repeat (5000) @(negedge clk_sys);
            {rst_in, stall} = 2'h0;
            hits = 0;
            repeat (20) @(posedge clk_sys) hits += soft_resume_pulse;
            `CHK("soft", !h, hits)
            `CHK("rst_end", 1'b0, bus_reset_active)
            $display("test reset %0d done", h);
        end
        connected = 1'b0;
        go_free = 1'b1;
        @(negedge clk_sys);
        go_free = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHK("bus_free", 1'b0, bsy_out)
        `CHK("left", 0, exp_in.size() + exp_rx.size())
        $display("test free done");
        end_of_test();
    end
endmodule : sti_target_tb_top
`default_nettype wire
